// [rtl/cyclic_timer_regs.vh]
// Register map, field layout and timing figures of the cyclic timer pair.
`ifndef CYCLIC_TIMER_REGS_VH
`define CYCLIC_TIMER_REGS_VH

// Clock rate in MHz; a cycle count is a time in microseconds times this.
`define CLK_MHZ        10

// Register indices; the byte address is four times the index.
`define IDX_WFLT       8'h09
`define IDX_TMR1       8'h0C
`define IDX_TMR2       8'h0D
`define IDX_STAT       8'h0F
`define IDX_HSW        8'h14

// Reset value and writable bits of a timer control register.
`define TMR_RESET      8'h00
`define TMR_MASK       8'h77
`define ON_LSB         4
`define PER_LSB        0
`define HSW_MASK       8'h77

// On-time and period codes with a special meaning.
`define ON_OFF_LOW     3'h0
`define ON_OFF_HIGH    3'h6
`define ON_SYNC        3'h7
`define PER_SYNC       3'h7

// High-side switch modes handled here.
`define HS_ON          3'h1
`define HS_TIMER1      3'h2
`define HS_TIMER2      3'h3

// Wake filter modes (two bits per wake input).
`define FLT_LONG       2'h1
`define FLT_TIMER1     2'h2

// Periods in microseconds.
`define T_PER0_US      10000
`define T_PER1_US      20000
`define T_PER2_US      50000
`define T_PER3_US      100000
`define T_PER4_US      200000
`define T_PER5_US      1000000
`define T_PER6_US      2000000

// On-times and settle times in microseconds.
`define T_ON1_US       100
`define T_ON2_US       300
`define T_ON3_US       1000
`define T_ON4_US       10000
`define T_ON5_US       20000
`define T_SET_SHORT_US 80
`define T_SET_MID_US   270
`define T_SET_LONG_US  800

// Wake filter times in microseconds.
`define T_FLT_SHORT_US 16
`define T_FLT_LONG_US  64

// Counter width; holds the longest period in cycles.
`define CNT_W          25
`define FLT_W          10

// Bus responses.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [rtl/pin_sync.v]
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         sys_rst,
  input  wire         ce,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_out
);

  // First stage; only the second stage reads it.
  reg [W-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////
  // Both stages freeze with the clock enable like all other state.
  always @(posedge mclk) begin
    if (sys_rst) begin
      stage1  <= {W{1'b0}};
      pin_out <= {W{1'b0}};
    end else if (ce) begin
      stage1  <= pin_in;
      pin_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// [rtl/cycle_timer_core.v]
// One cyclic timer: period, on-phase, settle flag and sync control.
`timescale 1ns/100ps
`default_nettype none
`include "cyclic_timer_regs.vh"

module cycle_timer_core #(
  parameter [7*`CNT_W-1:0] PER_TAB   = {(7*`CNT_W){1'b0}},
  parameter [8*`CNT_W-1:0] ON_TAB    = {(8*`CNT_W){1'b0}},
  parameter [`CNT_W-1:0]   SET_SHORT = 1,
  parameter [`CNT_W-1:0]   SET_MID   = 1,
  parameter [`CNT_W-1:0]   SET_LONG  = 1
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire [2:0] on_sel,
  input  wire [2:0] per_sel,
  input  wire       sync_lvl,
  output reg        timer_out,
  output reg        settle_done
);

  // Period length in cycles for a period code.
  function [`CNT_W-1:0] per_len;
    input [2:0] s;
    begin
      per_len = PER_TAB[s*`CNT_W +: `CNT_W];
    end
  endfunction

  // On-time length in cycles for an on-time code.
  function [`CNT_W-1:0] on_len;
    input [2:0] s;
    begin
      on_len = ON_TAB[s*`CNT_W +: `CNT_W];
    end
  endfunction

  // Settle time in cycles for an on-time code.
  function [`CNT_W-1:0] settle_len;
    input [2:0] s;
    begin
      case (s)
        3'h2:    settle_len = SET_MID;
        3'h3,
        3'h4,
        3'h5:    settle_len = SET_LONG;
        default: settle_len = SET_SHORT;
      endcase
    end
  endfunction

  reg  [`CNT_W-1:0] per_cnt;   // Position within the current period.
  reg  [`CNT_W-1:0] on_cnt;    // Cycles since the on-phase began.
  reg               sync_prev; // Last synchronised sync level.

  wire              running  = (on_sel != `ON_OFF_LOW) && (on_sel != `ON_OFF_HIGH);
  wire              sync_per = (per_sel == `PER_SYNC);
  wire              sync_on  = (on_sel == `ON_SYNC);
  wire              sync_rise = sync_lvl & ~sync_prev;
  wire              sync_fall = ~sync_lvl & sync_prev;
  wire [`CNT_W-1:0] on_next  = on_cnt + 1'b1;

  // Sync starts the on-phase; otherwise the period wrap does.
  wire              start    = sync_per ? sync_rise : (per_cnt == {`CNT_W{1'b0}});
  // Sync ends the on-phase; otherwise the on-time count does.
  wire              stop     = sync_on ? sync_fall : (on_next >= on_len(on_sel));

  ////////////////////////////////////////////////////////////////////////
  // Period and on-phase sequencing.
  always @(posedge mclk) begin
    if (sys_rst) begin
      per_cnt     <= {`CNT_W{1'b0}};
      on_cnt      <= {`CNT_W{1'b0}};
      sync_prev   <= 1'b0;
      timer_out   <= 1'b0;
      settle_done <= 1'b0;
    end else if (ce) begin
      sync_prev <= sync_lvl;
      if (!running) begin
        // Stopped, output held low or high.
        per_cnt     <= {`CNT_W{1'b0}};
        on_cnt      <= {`CNT_W{1'b0}};
        timer_out   <= (on_sel == `ON_OFF_HIGH);
        settle_done <= 1'b0;
      end else begin
        // Period counter wraps at the selected length.
        if (sync_per || (per_cnt >= per_len(per_sel) - 1'b1)) begin
          per_cnt <= {`CNT_W{1'b0}};
        end else begin
          per_cnt <= per_cnt + 1'b1;
        end
        // High from period start for the on-time.
        if (start) begin
          timer_out   <= 1'b1;
          on_cnt      <= {`CNT_W{1'b0}};
          settle_done <= 1'b0;
        end else if (timer_out) begin
          on_cnt <= on_next;
          if (stop) begin
            timer_out   <= 1'b0;
            settle_done <= 1'b0;
          end else if (on_next >= settle_len(on_sel)) begin
            // Settle time counted from on-phase start.
            settle_done <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/cyclic_sense_timer_pair.v]
// Cyclic sense timer pair with AXI4-Lite registers, switches and wake filters.
`timescale 1ns/100ps
`default_nettype none
`include "cyclic_timer_regs.vh"

module cyclic_sense_timer_pair #(
  parameter [`CNT_W-1:0] PER0_CYC      = `T_PER0_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER1_CYC      = `T_PER1_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER2_CYC      = `T_PER2_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER3_CYC      = `T_PER3_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER4_CYC      = `T_PER4_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER5_CYC      = `T_PER5_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PER6_CYC      = `T_PER6_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ON1_CYC       = `T_ON1_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ON2_CYC       = `T_ON2_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ON3_CYC       = `T_ON3_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ON4_CYC       = `T_ON4_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ON5_CYC       = `T_ON5_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] SET_SHORT_CYC = `T_SET_SHORT_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] SET_MID_CYC   = `T_SET_MID_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] SET_LONG_CYC  = `T_SET_LONG_US * `CLK_MHZ
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        soft_rst,
  input  wire        restart_entry,
  input  wire        restart_hs_clear,
  input  wire        sync_pin,
  input  wire [3:0]  wake_pin,
  output reg  [3:0]  high_side_output,
  output wire [3:0]  wake_level
);

  // Filter lengths are short, so they stay local constants.
  localparam [`FLT_W-1:0] FLT_SHORT_CYC = `T_FLT_SHORT_US * `CLK_MHZ;
  localparam [`FLT_W-1:0] FLT_LONG_CYC  = `T_FLT_LONG_US * `CLK_MHZ;

  // Lookup tables handed to both timers; unused on-time codes hold zero, period code 7 has no entry.
  localparam [7*`CNT_W-1:0] PER_TAB = {PER6_CYC, PER5_CYC, PER4_CYC, PER3_CYC,
                                       PER2_CYC, PER1_CYC, PER0_CYC};
  localparam [8*`CNT_W-1:0] ON_TAB  = {{(2*`CNT_W){1'b0}}, ON5_CYC, ON4_CYC,
                                       ON3_CYC, ON2_CYC, ON1_CYC, {`CNT_W{1'b0}}};

  ////////////////////////////////////////////////////////////////////////
  // Register decode shared by the read and the write path.

  // True for an index that holds a register.
  function reg_hit;
    input [7:0] idx;
    begin
      reg_hit = (idx == `IDX_WFLT) || (idx == `IDX_TMR1) || (idx == `IDX_TMR2) ||
                (idx == `IDX_STAT) || (idx == `IDX_HSW);
    end
  endfunction

  reg  [7:0]  first_cycle_timer_control;  // Timer one on-time and period.
  reg  [7:0]  second_cycle_timer_control; // Timer two on-time and period.
  reg  [7:0]  wake_filter_config;         // Four 2-bit wake filter modes.
  reg  [15:0] hs_mode;                    // Four 3-bit switch modes.

  reg  [7:0]  aw_idx;                     // Held write index.
  reg         aw_full;                    // Write address captured.
  reg  [7:0]  w_lo;                       // Held write data, byte 0.
  reg  [7:0]  w_hi;                       // Held write data, byte 1.
  reg  [1:0]  w_strb;                     // Held strobes of bytes 0 and 1.
  reg         w_full;                     // Write data captured.

  wire [1:0]  t_out;                      // Timer outputs.
  wire [1:0]  t_settle;                   // Timer settle flags.
  wire        sync_lvl;                   // Synchronised sync pin.
  wire [3:0]  wake_sync;                  // Synchronised wake pins.

  // Fields taken from both registers at the same places.
  wire [2:0]  first_timer_on_time_sel  = first_cycle_timer_control[`ON_LSB +: 3];
  wire [2:0]  first_timer_period_sel   = first_cycle_timer_control[`PER_LSB +: 3];
  wire [2:0]  second_timer_on_time_sel = second_cycle_timer_control[`ON_LSB +: 3];
  wire [2:0]  second_timer_period_sel  = second_cycle_timer_control[`PER_LSB +: 3];
  wire [11:0] sel_pack = {second_timer_on_time_sel, second_timer_period_sel,
                          first_timer_on_time_sel, first_timer_period_sel};

  // The top bit of each filter field marks a cyclic mode (C or D).
  wire        cyclic_active = wake_filter_config[7] | wake_filter_config[5] |
                              wake_filter_config[3] | wake_filter_config[1];

  // A write is carried out once both halves are held and no answer is pending.
  wire        do_write = aw_full & w_full & ~s_axi_bvalid;

  // Read data for an index; gaps and reserved bits read zero.
  function [31:0] reg_read;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_WFLT: reg_read = {24'h000000, wake_filter_config};
        // Reserved bits are never stored, so read zero.
        `IDX_TMR1: reg_read = {24'h000000, first_cycle_timer_control};
        `IDX_TMR2: reg_read = {24'h000000, second_cycle_timer_control};
        `IDX_STAT: reg_read = {24'h000000, wake_level, t_settle, t_out};
        `IDX_HSW:  reg_read = {16'h0000, hs_mode};
        default:   reg_read = 32'h00000000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; sync and wake pins come from outside this clock.
  pin_sync #(
    .W (5)
  ) u_pin_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin_in  ({wake_pin, sync_pin}),
    .pin_out ({wake_sync, sync_lvl})
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel handshake and response.
  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_idx        <= 8'h00;
      w_lo          <= 8'h00;
      w_hi          <= 8'h00;
      w_strb        <= 2'h0;
    end else if (ce) begin
      // Address and data are accepted in either order.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx        <= s_axi_awaddr[9:2];
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_lo         <= s_axi_wdata[7:0];
        w_hi         <= s_axi_wdata[15:8];
        w_strb       <= s_axi_wstrb[1:0];
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        // Unmapped indices answer with a slave error; address bits 11:10 are not decoded.
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_hit(aw_idx) && (aw_idx == aw_idx)) ? `RESP_OKAY
                                                                : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // Both halves are released only once the answer is taken.
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel; data is ready one edge after the address is taken.
  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= reg_read(s_axi_araddr[9:2]);
        s_axi_rresp   <= reg_hit(s_axi_araddr[9:2]) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage. Hardware clears come last so they win over a
  // write in the same cycle; a config write lost to a restart is safer
  // than a timer left running on stale settings.
  always @(posedge mclk) begin
    if (sys_rst) begin
      first_cycle_timer_control  <= `TMR_RESET;
      second_cycle_timer_control <= `TMR_RESET;
      wake_filter_config         <= 8'h00;
      hs_mode                    <= 16'h0000;
    end else if (ce) begin
      if (do_write) begin
        case (aw_idx)
          `IDX_TMR1: begin
            if (w_strb[0]) begin
              first_cycle_timer_control <= w_lo & `TMR_MASK;
            end
          end
          `IDX_TMR2: begin
            if (w_strb[0]) begin
              second_cycle_timer_control <= w_lo & `TMR_MASK;
            end
          end
          `IDX_WFLT: begin
            if (w_strb[0]) begin
              wake_filter_config <= w_lo;
            end
          end
          `IDX_HSW: begin
            if (w_strb[0]) begin
              hs_mode[7:0] <= w_lo & `HSW_MASK;
            end
            if (w_strb[1]) begin
              hs_mode[15:8] <= w_hi & `HSW_MASK;
            end
          end
          default: begin
            // Status and unmapped indices store nothing.
          end
        endcase
      end
      // Switch clear in cyclic sense clears timers.
      if (restart_hs_clear && cyclic_active) begin
        first_cycle_timer_control  <= `TMR_RESET;
        second_cycle_timer_control <= `TMR_RESET;
        hs_mode                    <= 16'h0000;
      end
      // Soft reset and restart entry stop both.
      if (soft_rst || restart_entry) begin
        first_cycle_timer_control  <= `TMR_RESET;
        second_cycle_timer_control <= `TMR_RESET;
      end
      // Soft reset also returns the other registers to power-on values.
      if (soft_rst) begin
        wake_filter_config <= 8'h00;
        hs_mode            <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two identical timers.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_timer
      // Timer runs as soon as its on-time code runs.
      cycle_timer_core #(
        .PER_TAB   (PER_TAB),
        .ON_TAB    (ON_TAB),
        .SET_SHORT (SET_SHORT_CYC),
        .SET_MID   (SET_MID_CYC),
        .SET_LONG  (SET_LONG_CYC)
      ) u_timer (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .ce          (ce),
        .on_sel      (sel_pack[g*6+3 +: 3]),
        .per_sel     (sel_pack[g*6 +: 3]),
        .sync_lvl    (sync_lvl),
        .timer_out   (t_out[g]),
        .settle_done (t_settle[g])
      );
    end
  endgenerate

  // Long on-times come from the same tables.

  ////////////////////////////////////////////////////////////////////////
  // Wake filters, one per wake input. A level change must hold for the
  // whole filter time before it is taken; in a cyclic mode the count only
  // runs while the chosen timer has settled, so the pin is never judged
  // while the switch that feeds it is still rising.
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_filter
      reg  [`FLT_W-1:0] flt_cnt;  // Cycles the pin has differed.
      reg               lvl;      // Filtered level.
      wire [1:0]        mode = wake_filter_config[2*g +: 2];
      // Cyclic modes gate the filter on settle.
      wire              enable = (mode[1] == 1'b0) ? 1'b1 : t_settle[mode[0]];
      wire [`FLT_W-1:0] limit  = (mode == `FLT_LONG) ? FLT_LONG_CYC : FLT_SHORT_CYC;
      always @(posedge mclk) begin
        if (sys_rst) begin
          flt_cnt <= {`FLT_W{1'b0}};
          lvl     <= 1'b0;
        end else if (ce) begin
          if (!enable || (wake_sync[g] == lvl)) begin
            flt_cnt <= {`FLT_W{1'b0}};
          end else if (flt_cnt + 1'b1 >= limit) begin
            flt_cnt <= {`FLT_W{1'b0}};
            lvl     <= wake_sync[g];
          end else begin
            flt_cnt <= flt_cnt + 1'b1;
          end
        end
      end
      assign wake_level[g] = lvl;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // High-side switch drive. Modes beyond timer control (PWM) are served
  // elsewhere and read as off here.
  integer i;
  always @(posedge mclk) begin
    if (sys_rst) begin
      high_side_output <= 4'h0;
    end else if (ce) begin
      for (i = 0; i < 4; i = i + 1) begin
        case (hs_mode[4*i +: 3])
          `HS_ON:     high_side_output[i] <= 1'b1;
          // Switch follows timer one or two.
          `HS_TIMER1: high_side_output[i] <= t_out[0];
          `HS_TIMER2: high_side_output[i] <= t_out[1];
          default:    high_side_output[i] <= 1'b0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [tb/switch_side_model.sv]
// Far side model: external sync driver and wake input sources.
`timescale 1ns/100ps
`default_nettype none
module switch_side_model (
  input  wire       mclk,
  input  wire       sync_req,
  output reg        sync_pin,
  output reg  [3:0] wake_pin
);
  initial begin
    sync_pin = 1'b0;
    wake_pin = 4'h0;
  end
  // Pins change one edge after the request, as an outside driver would.
  always @(posedge mclk) begin
    sync_pin <= sync_req;
    wake_pin <= {4{sync_req}};
  end
endmodule
`default_nettype wire

// [tb/timer_pair_props.sv]
// Checker for bus handshakes, reserved bits and clears of the timer pair.
`timescale 1ns/100ps
`default_nettype none
module timer_pair_props (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        soft_rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  high_side_output
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ridx;  // Index of the read now being answered.
  // Remember the index at the address handshake.
  always @(posedge mclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ridx <= s_axi_araddr[9:2];
    end
  end
  idle_after_rst_a: assert property ($fell(sys_rst) |-> s_axi_awready && s_axi_wready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && high_side_output == 4'h0)
    else $error("bus or outputs not idle after reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  resv_zero_a: assert property (s_axi_rvalid && (ridx == 8'h0C || ridx == 8'h0D)
    |-> s_axi_rdata[31:7] == 25'h0 && !s_axi_rdata[3]) else $error("reserved bits set");
  soft_clear_a: assert property (soft_rst |-> ##[1:4] high_side_output == 4'h0)
    else $error("outputs not cleared by soft reset");
endmodule
bind cyclic_sense_timer_pair timer_pair_props props_i (.mclk, .sys_rst, .soft_rst,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .high_side_output);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the cyclic timer pair.
`timescale 1ns/100ps
`default_nettype none
module tb;
  reg         mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0;
  reg         restart_entry = 1'b0, restart_hs_clear = 1'b0, sync_req = 1'b0, ce = 1'b1;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  wire [3:0]  wake_level;
  // Shortened cycle counts so every code fits in a short run.
  localparam int P0 = 40, P1 = 50, P2 = 60, P3 = 70, P4 = 80, P5 = 90, P6 = 100;
  localparam int N1 = 5, N2 = 7, N3 = 9, N4 = 11, N5 = 13, S1 = 2, S2 = 3, S3 = 4;
  reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_pin;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0]  wake_pin, high_side_output;
  int         bad_count = 0, n_checks = 0, hi, pr;
  int         per_t[7] = '{40, 50, 60, 70, 80, 90, 100};  // Shortened periods in cycles.
  int         on_t[5] = '{5, 7, 9, 11, 13};               // Shortened on-times in cycles.
  always #50 mclk = ~mclk;
  cyclic_sense_timer_pair #(.PER0_CYC(P0), .PER1_CYC(P1), .PER2_CYC(P2), .PER3_CYC(P3),
    .PER4_CYC(P4), .PER5_CYC(P5), .PER6_CYC(P6), .ON1_CYC(N1), .ON2_CYC(N2), .ON3_CYC(N3),
    .ON4_CYC(N4), .ON5_CYC(N5), .SET_SHORT_CYC(S1), .SET_MID_CYC(S2), .SET_LONG_CYC(S3)) dut (
    .mclk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .soft_rst, .restart_entry, .restart_hs_clear, .sync_pin,
    .wake_pin, .high_side_output, .wake_level);
  switch_side_model far_i (.mclk, .sync_req, .sync_pin, .wake_pin);
  ////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write; address and data are released each on its own handshake.
  task wr(input [7:0] i, input [31:0] d, input [1:0] er);
    reg a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge mclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (a | w) begin
      @(posedge mclk);
      if (a && s_axi_awready) begin a = 1'b0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge mclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input [7:0] i, input [31:0] exp, input [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  // One-cycle strobe: 0 soft reset, 1 restart entry, 2 restart switch clear.
  task hw_pulse(input [1:0] k);
    @(posedge mclk);
    {soft_rst, restart_entry, restart_hs_clear} <= 3'b100 >> k;
    @(posedge mclk);
    {soft_rst, restart_entry, restart_hs_clear} <= 3'b000;
  endtask
  // Measures high cycles and rise-to-rise cycles of one switch output.
  task meas(input int b);
    hi = 0;
    while (high_side_output[b] !== 1'b0) @(posedge mclk);
    while (high_side_output[b] !== 1'b1) @(posedge mclk);
    while (high_side_output[b] === 1'b1) begin @(posedge mclk); hi++; end
    pr = hi;
    while (high_side_output[b] !== 1'b1) begin @(posedge mclk); pr++; end
  endtask
  task t_regs;
    rd(8'h0C, 0, 2'h0);
    rd(8'h0D, 0, 2'h0);
    wr(8'h0C, 32'hFFFFFFFF, 2'h0);
    rd(8'h0C, 32'h77, 2'h0);
    wr(8'h0D, 32'hFFFFFFFF, 2'h0);
    rd(8'h0D, 32'h77, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'h0C, 32'h0, 2'h0);
    rd(8'h0C, 32'h77, 2'h0);
    s_axi_wstrb <= 4'hF;
    wr(8'h01, 32'h5, 2'h2);
    rd(8'h01, 0, 2'h2);
  endtask
  task t_static;
    wr(8'h14, 32'h32, 2'h0);
    wr(8'h0C, 32'h60, 2'h0);
    repeat (8) @(posedge mclk);
    chk(high_side_output[0], 1);
    ce <= 1'b0;
    hw_pulse(1);
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(high_side_output[0], 1);
    wr(8'h0C, 32'h00, 2'h0);
    repeat (8) @(posedge mclk);
    chk(high_side_output[0], 0);
  endtask
  // Each on-time code 1 to 5 and each period code 0 to 6 on both timers.
  task t_codes;
    for (int k = 0; k < 12; k++) begin
      wr(8'h0C, (k < 5) ? k * 16 + 22 : 16 + k - 5, 2'h0);
      wr(8'h0D, (k < 5) ? k * 16 + 22 : 16 + k - 5, 2'h0);
      for (int b = 0; b < 2; b++) begin
        meas(b);
        meas(b);
        if (k < 5) chk(hi, on_t[k]);
        else chk(pr, per_t[k - 5]);
      end
    end
  endtask
  task t_sync;
    wr(8'h0C, 32'h77, 2'h0);
    @(posedge mclk);
    sync_req <= 1'b1;
    repeat (200) @(posedge mclk);
    chk(high_side_output[0], 1);
    chk(wake_level, 4'hF);
    sync_req <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(high_side_output[0], 0);
  endtask
  task t_clear;
    wr(8'h0C, 32'h11, 2'h0);
    hw_pulse(1);
    rd(8'h0C, 0, 2'h0);
    wr(8'h0C, 32'h11, 2'h0);
    wr(8'h09, 32'h02, 2'h0);
    hw_pulse(2);
    rd(8'h0C, 0, 2'h0);
    wr(8'h09, 32'h00, 2'h0);
    wr(8'h0C, 32'h11, 2'h0);
    hw_pulse(2);
    rd(8'h0C, 32'h11, 2'h0);
    wr(8'h14, 32'h01, 2'h0);
    hw_pulse(0);
    rd(8'h0C, 0, 2'h0);
    rd(8'h14, 0, 2'h0);
  endtask
  task wrap_up;
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_static;
    t_codes;
    t_sync;
    t_clear;
    wrap_up;
  end
  // Watchdog: the tests need about 7000 cycles.
  initial begin
    #4000000;
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
